// *** hw/ebt_pkg.sv ***
package ebt_pkg;
  // register offsets on the plain port
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_COUNT   = 2'h1;
  localparam logic [1:0] ADDR_COMPARE = 2'h2;
  localparam logic [1:0] ADDR_STATUS  = 2'h3;

  // control field positions
  localparam int CTL_FORCE_BIT  = 7;
  localparam int CTL_WGM_LO_BIT = 6;
  localparam int CTL_ACT_HI_BIT = 5;
  localparam int CTL_ACT_LO_BIT = 4;
  localparam int CTL_WGM_HI_BIT = 3;
  localparam int CTL_CS_MSB     = 2;

  // status field positions (write one to clear)
  localparam int STS_OVF_BIT = 0;
  localparam int STS_CMP_BIT = 1;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX       = 8'hff;
  localparam logic [7:0] CNT_BOTTOM    = 8'h00;
  localparam int         PRESCALE_MAX  = 1024;
  localparam int         PC_PERIOD     = 510;

  typedef enum logic [1:0] {
    EBT_NORMAL = 2'h0,
    EBT_PCPWM  = 2'h1,
    EBT_CLEAR  = 2'h2,
    EBT_FPWM   = 2'h3
  } ebt_mode_t;

  typedef enum logic [1:0] {
    EBT_UP   = 2'b01,
    EBT_DOWN = 2'b10
  } ebt_dir_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ebt_req_t;
endpackage

// *** hw/ebt_timer.sv ***
`timescale 1ns/1ps
// Summary of operation
// R01: phase correct counts bottom up to 0xff then back down, repeating.
// R02: at max in phase correct, reverse and hold max one tick.
// R03: phase correct sets overflow flag at bottom, not at max.
// R04: phase correct actions: 00 off, 01 reserved, 10/11 up/down clear-set pairs.
// R05: phase correct compare at bottom or max gives constant output level.
// R06: output at max equals up-count match result for symmetry.
// R07: start above compare misses up match; output fixed at max instead.
// R08: phase correct period is 510 ticks.
// R09: timer tick is a clock enable on the single clock.
// R10: force compare bit 7 applies match in non-pwm modes; reads zero.
// R11: forced match sets no flag and does not clear counter.
// R12: software writes force as zero in pwm modes; ignored there.
// R13: waveform mode sits at control bits 6 and 3.
// R14: bit3 high, bit6 low: 00 normal, 01 pc pwm, 10 clear, 11 fast.
// R15: top 0xff except clear mode; compare buffered to top in pwm modes.
// R16: action bits 5:4; nonzero connects output, driver needs direction bit.
// R17: non-pwm actions: 00 off, 01 toggle, 10 clear, 11 set.
// R18: fast pwm: 10 clear on match set at top, 11 inverse.
// R19: pwm with compare at top and action high ignores match, acts at top.
// R20: clock select 0 stop, 1 direct, then /8 /32 /64 /128 /256 /1024.
// R21: count register read/write; a write blocks next tick's match. Clear mode still clears the counter on that match.
// R22: compare value compared continuously; match sets compare flag.
// R23: normal mode wraps 0xff to 0; overflow set as count becomes zero.
// R24: clear mode clears counter on match with compare value.
// R25: fast pwm counts to max then clears on next tick.
// R26: stopped clock freezes counter, flags, output; writes still accepted.
// R27: compare flag set on equality alike in every mode.
module ebt_timer
  import ebt_pkg::*;
#(
  parameter int PRESCALE_W = 10
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire ebt_pkg::ebt_req_t req,
  output logic [7:0]            rdata,
  input  wire logic             pin_direction_bit,
  input  wire logic             port_data,
  output logic                  compare_output,
  output logic                  compare_output_pin,
  output logic                  compare_output_oe_n,
  output logic                  overflow_flag,
  output logic                  compare_flag
);
  import ebt_pkg::*;

  logic [7:0]            control_r;
  logic [7:0]            count_r;
  logic [7:0]            compare_buf_r;
  logic [7:0]            compare_act_r;
  logic                  oc_r;
  logic                  ovf_r;
  logic                  cmp_r;
  logic                  block_r;
  ebt_dir_t              dir_r;
  logic [PRESCALE_W-1:0] pre_r;
  logic                  timer_tick;
  logic                  tick_pre;
  ebt_mode_t             mode;
  logic [1:0]            action;
  logic [2:0]            clock_select;
  logic                  is_pwm;
  logic                  at_top;
  logic                  match;
  logic                  match_ok;
  logic                  wr_ctl;
  logic                  wr_cnt;
  logic                  wr_cmp;
  logic                  wr_sts;
  logic                  force_hit;
  logic [7:0]            count_nxt;
  ebt_dir_t              dir_nxt;
  logic                  oc_nxt;
  logic                  ovf_set;

  assign wr_ctl = req.wr && req.addr == ADDR_CONTROL;
  assign wr_cnt = req.wr && req.addr == ADDR_COUNT;
  assign wr_cmp = req.wr && req.addr == ADDR_COMPARE;
  assign wr_sts = req.wr && req.addr == ADDR_STATUS;

  // R13: mode bits split across the control byte
  // R14: bit 3 is the high mode bit
  assign mode         = ebt_mode_t'({control_r[CTL_WGM_HI_BIT], control_r[CTL_WGM_LO_BIT]});
  assign action       = control_r[CTL_ACT_HI_BIT:CTL_ACT_LO_BIT];
  assign clock_select = control_r[CTL_CS_MSB:0];
  assign is_pwm       = mode == EBT_PCPWM || mode == EBT_FPWM;

  // R20: divider selected by clock select
  function automatic logic div_pulse(input logic [2:0] cs, input logic [PRESCALE_W-1:0] p);
    logic r;
    r = 1'b0;
    unique case (cs)
      3'h0: r = 1'b0;
      3'h1: r = 1'b1;
      3'h2: r = p[2:0] == '1;
      3'h3: r = p[4:0] == '1;
      3'h4: r = p[5:0] == '1;
      3'h5: r = p[6:0] == '1;
      3'h6: r = p[7:0] == '1;
      3'h7: r = p[9:0] == '1;
    endcase
    return r;
  endfunction

  // R17: non-pwm action on a real or forced match
  function automatic logic act_apply(input logic [1:0] a, input logic o);
    logic r;
    r = o;
    unique case (a)
      2'h0: r = o;
      2'h1: r = ~o;
      2'h2: r = 1'b0;
      2'h3: r = 1'b1;
    endcase
    return r;
  endfunction

  // free-running prescaler; the /1024 tap sets its width
  always_ff @(posedge clock) begin
    if (rst) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  assign tick_pre = div_pulse(clock_select, pre_r);
  // R09: tick is only an enable, never a clock
  // R26: stopped select yields no tick
  assign timer_tick = tick_pre;

  // R15: top is compare in ctc, 0xff elsewhere
  assign at_top = (mode == EBT_CLEAR) ? (count_r == compare_act_r) : (count_r == CNT_MAX);

  // R22: continuous equality; R21: blocked after a count write
  assign match    = count_r == compare_act_r;
  assign match_ok = match && !block_r;

  // R12: force ignored in pwm modes
  // R10: strobe acts in non-pwm modes
  // the mode and action being written decide the forced effect
  assign force_hit = wr_ctl && req.wdata[CTL_FORCE_BIT] && !req.wdata[CTL_WGM_LO_BIT];

  // counting sequence
  always_comb begin
    count_nxt = count_r;
    dir_nxt   = dir_r;
    ovf_set   = 1'b0;
    unique case (mode)
      EBT_NORMAL: begin
        // R23: wrap, overflow as zero is reached
        count_nxt = count_r + 8'h01;
        ovf_set   = count_r == CNT_MAX;
      end
      EBT_CLEAR: begin
        // R24: clear on match
        count_nxt = match ? CNT_BOTTOM : count_r + 8'h01;
        ovf_set   = count_r == CNT_MAX;
      end
      EBT_FPWM: begin
        // R25: single slope
        count_nxt = count_r + 8'h01;
        ovf_set   = count_r == CNT_MAX;
      end
      EBT_PCPWM: begin
        // R01: dual slope; R02: max held one tick by turning there
        // R08: 255 up plus 255 down gives 510 ticks
        if (dir_r == EBT_UP) begin
          if (count_r == CNT_MAX) begin
            dir_nxt   = EBT_DOWN;
            count_nxt = count_r - 8'h01;
          end else begin
            count_nxt = count_r + 8'h01;
          end
        end else begin
          if (count_r == CNT_BOTTOM) begin
            dir_nxt   = EBT_UP;
            count_nxt = count_r + 8'h01;
          end else begin
            count_nxt = count_r - 8'h01;
          end
        end
        // R03: overflow as bottom is reached
        ovf_set = dir_r == EBT_DOWN && count_r == 8'h01;
      end
    endcase
  end

  // waveform generator
  always_comb begin
    oc_nxt = oc_r;
    unique case (mode)
      EBT_NORMAL, EBT_CLEAR: begin
        // R17: toggle, clear, set on match
        if (match_ok) begin
          oc_nxt = act_apply(action, oc_r);
        end
      end
      EBT_FPWM: begin
        // R18: action at top wins; R19: match ignored when compare is top
        if (action[1]) begin
          if (count_r == CNT_MAX) begin
            oc_nxt = ~action[0];
          end else if (match_ok) begin
            oc_nxt = action[0];
          end
        end
      end
      EBT_PCPWM: begin
        if (action[1]) begin
          // R06: at max take the up-count match result
          // R07: covers a start above compare
          // R05: with action 10, compare 0 stays low, compare max stays high
          // R19: match at top replaced by this action
          if (count_r == CNT_MAX) begin
            oc_nxt = (compare_act_r == CNT_MAX) ? ~action[0] : action[0];
          end else if (match_ok) begin
            // R04: 10 clears going up, sets going down; bottom counts as up
            oc_nxt = (dir_r == EBT_UP || count_r == CNT_BOTTOM) ? action[0] : ~action[0];
          end
        end
      end
    endcase
    // R10: forced match uses the action just written
    if (force_hit) begin
      oc_nxt = act_apply(req.wdata[CTL_ACT_HI_BIT:CTL_ACT_LO_BIT], oc_r);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      control_r <= CONTROL_RESET;
    end else if (wr_ctl) begin
      // R10: force bit not stored so it reads zero
      control_r <= {1'b0, req.wdata[6:0]};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count_r <= COUNT_RESET;
      dir_r   <= EBT_UP;
    end else if (wr_cnt) begin
      // R21: software writes the counter directly
      count_r <= req.wdata;
    end else if (timer_tick) begin
      count_r <= count_nxt;
      dir_r   <= mode == EBT_PCPWM ? dir_nxt : EBT_UP;
    end
  end

  // R21: write blocks the match of the following tick
  always_ff @(posedge clock) begin
    if (rst) begin
      block_r <= 1'b0;
    end else if (wr_cnt) begin
      block_r <= 1'b1;
    end else if (timer_tick) begin
      block_r <= 1'b0;
    end
  end

  // R15: immediate outside pwm, loaded at top in pwm modes
  always_ff @(posedge clock) begin
    if (rst) begin
      compare_buf_r <= COMPARE_RESET;
      compare_act_r <= COMPARE_RESET;
    end else begin
      if (wr_cmp) begin
        compare_buf_r <= req.wdata;
      end
      if (!is_pwm) begin
        compare_act_r <= wr_cmp ? req.wdata : compare_buf_r;
      end else if (timer_tick && at_top) begin
        compare_act_r <= compare_buf_r;
      end
    end
  end

  // R11: forced match alters only the output
  always_ff @(posedge clock) begin
    if (rst) begin
      oc_r <= 1'b0;
    end else if (timer_tick || force_hit) begin
      oc_r <= oc_nxt;
    end
  end

  // flags: set wins over a write-one clear
  always_ff @(posedge clock) begin
    if (rst) begin
      ovf_r <= 1'b0;
      cmp_r <= 1'b0;
    end else begin
      if (timer_tick && ovf_set) begin
        ovf_r <= 1'b1;
      end else if (wr_sts && req.wdata[STS_OVF_BIT]) begin
        ovf_r <= 1'b0;
      end
      // R27: same equality rule in every mode
      if (timer_tick && match_ok) begin
        cmp_r <= 1'b1;
      end else if (wr_sts && req.wdata[STS_CMP_BIT]) begin
        cmp_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        ADDR_CONTROL: rdata <= control_r;
        ADDR_COUNT:   rdata <= count_r;
        ADDR_COMPARE: rdata <= compare_buf_r;
        ADDR_STATUS:  rdata <= {6'h00, cmp_r, ovf_r};
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  assign compare_output = oc_r;
  assign overflow_flag  = ovf_r;
  assign compare_flag   = cmp_r;
  // R16: nonzero action takes over the pin; direction enables driver
  assign compare_output_pin  = (action != 2'h0) ? oc_r : port_data;
  assign compare_output_oe_n = ~pin_direction_bit;

  // R23: overflow in normal mode follows a wrap to zero
  property p_norm_ovf;
    @(posedge clock) disable iff (rst)
      (timer_tick && mode == EBT_NORMAL && count_r == CNT_MAX && !wr_cnt) |=> (count_r == 8'h00 && ovf_r);
  endproperty
  a_norm_ovf: assert property (p_norm_ovf) else $error("normal wrap missed overflow"); // R23

  property p_pc_turn;
    @(posedge clock) disable iff (rst)
      (timer_tick && mode == EBT_PCPWM && dir_r == EBT_UP && count_r == CNT_MAX && !wr_cnt && !wr_ctl)
        |=> (dir_r == EBT_DOWN && count_r == 8'hfe);
  endproperty
  a_pc_turn: assert property (p_pc_turn) else $error("phase correct did not turn at max"); // R02

  property p_pc_no_max_ovf;
    @(posedge clock) disable iff (rst)
      (timer_tick && mode == EBT_PCPWM && count_r == CNT_MAX && !ovf_r && !wr_ctl) |=> !ovf_r;
  endproperty
  a_pc_no_max_ovf: assert property (p_pc_no_max_ovf) else $error("overflow at max in phase correct"); // R03

  property p_clr_clear;
    @(posedge clock) disable iff (rst)
      (timer_tick && mode == EBT_CLEAR && match && !wr_cnt && !wr_ctl) |=> count_r == 8'h00;
  endproperty
  a_clr_clear: assert property (p_clr_clear) else $error("clear mode did not clear on match"); // R24

  property p_force_noflag;
    @(posedge clock) disable iff (rst)
      (force_hit && !timer_tick && !cmp_r) |=> !cmp_r;
  endproperty
  a_force_noflag: assert property (p_force_noflag) else $error("forced match set flag"); // R11

  property p_block;
    @(posedge clock) disable iff (rst)
      (timer_tick && block_r && !cmp_r) |=> !cmp_r;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked after count write"); // R21

  property p_stop;
    @(posedge clock) disable iff (rst)
      (clock_select == 3'h0 && !req.wr) |=> $stable(count_r) && $stable(oc_r);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped timer changed state"); // R26

  property p_force_rd0;
    @(posedge clock) disable iff (rst)
      req.rd && req.addr == ADDR_CONTROL |=> !rdata[CTL_FORCE_BIT];
  endproperty
  a_force_rd0: assert property (p_force_rd0) else $error("force bit read as one"); // R10

  property p_cmp_set;
    @(posedge clock) disable iff (rst)
      (timer_tick && match_ok) |=> cmp_r;
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("compare flag not set"); // R22

  c_pc_turn: cover property (@(posedge clock) mode == EBT_PCPWM && dir_r == EBT_DOWN && count_r == 8'h00);
  c_clr:     cover property (@(posedge clock) mode == EBT_CLEAR && timer_tick && match_ok);
  c_fpwm:    cover property (@(posedge clock) mode == EBT_FPWM && timer_tick && count_r == CNT_MAX);
  c_force:   cover property (@(posedge clock) force_hit);
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
  import ebt_pkg::*;
  logic       clock = 1'b0;
  logic       rst   = 1'b1;
  ebt_req_t   req   = '0;
  logic       dir   = 1'b0;
  logic       pdata = 1'b0;
  logic [7:0] rdata;
  logic       cout, cpin, coe_n, ovf, cmpf;
  int         n_errors   = 0;
  int         n_compared = 0;
  int         cyc        = 0;
  int         divs[8]    = '{0, 1, 8, 32, 64, 128, 256, 1024};

  always #25 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  ebt_timer uut (.clock(clock), .rst(rst), .req(req), .rdata(rdata), .pin_direction_bit(dir),
    .port_data(pdata), .compare_output(cout), .compare_output_pin(cpin),
    .compare_output_oe_n(coe_n), .overflow_flag(ovf), .compare_flag(cmpf));

  function automatic logic [7:0] ctl(input logic [1:0] m, input logic [1:0] a, input logic [2:0] cs,
                                     input logic f);
    logic [7:0] x;
    x = 8'h00;
    x[CTL_FORCE_BIT] = f;
    x[CTL_WGM_LO_BIT] = m[0];
    x[CTL_WGM_HI_BIT] = m[1];
    x[CTL_ACT_HI_BIT:CTL_ACT_LO_BIT] = a;
    x[CTL_CS_MSB:0] = cs;
    return x;
  endfunction

  // forced match result in non-pwm modes
  function automatic logic force_exp(input logic [1:0] a, input logic o);
    return (a == 2'h0) ? o : (a == 2'h1) ? !o : (a == 2'h3);
  endfunction

  function automatic logic sel(input int w);
    case (w)
      0: return ovf;
      1: return cmpf;
      2: return cout;
      default: return !cout;
    endcase
  endfunction

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clock);
    req.wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clock);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clock);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_hi(input int w, output int t);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge clock);
      #1;
      if (sel(w) === 1'b1) break;
    end
    chk("wait_bound", 16'(i < 3000), 16'h0001);
    t = cyc;
  endtask

  task automatic rise(output int t);
    int d;
    wait_hi(3, d);
    wait_hi(2, t);
  endtask

  // gap between two output rises (w=2) or two overflow sets (w=0)
  task automatic period(input int w, input int exp, input logic rew);
    int a, b;
    if (w == 2) begin
      rise(a);
      rise(b);
    end else begin
      wr(ADDR_STATUS, 8'h03);
      if (rew) wr(ADDR_COUNT, CNT_MAX);
      wait_hi(0, a);
      wr(ADDR_STATUS, 8'h03);
      if (rew) wr(ADDR_COUNT, CNT_MAX);
      wait_hi(0, b);
    end
    chk("period", 16'(b - a), 16'(exp));
  endtask

  task automatic steady(input logic e);
    int bad;
    bad = 0;
    repeat (1100) @(posedge clock);
    repeat (520) begin
      @(posedge clock);
      #1;
      if (cout !== e) bad++;
    end
    chk("steady", 16'(bad), 16'h0000);
  endtask

  initial begin
    #(50 * 100000);
    n_errors++;
    test_done();
  end

  initial begin
    logic [7:0] v, w, c, r;
    logic [1:0] a, m;
    logic       o;
    int         k, t;
    void'($urandom(52));
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(ADDR_CONTROL, v);
    chk("control", 16'(v), 16'(CONTROL_RESET));
    rd(ADDR_COUNT, v);
    chk("count", 16'(v), 16'(COUNT_RESET));
    rd(ADDR_COMPARE, v);
    chk("compare", 16'(v), 16'(COMPARE_RESET));
    chk("flags_out", 16'({ovf, cmpf, cout}), 16'h0000);
    // stopped timer: registers, forced match, pin muxing
    for (k = 0; k < 8; k++) begin
      m = 2'($urandom);
      a = 2'($urandom);
      // force only written in non-pwm modes
      c = ctl(m, a, 3'h0, m[0] ? 1'b0 : 1'($urandom));
      v = 8'($urandom);
      w = ~v;
      o = cout;
      dir <= 1'($urandom);
      pdata <= 1'($urandom);
      wr(ADDR_CONTROL, c);
      wr(ADDR_COUNT, v);
      wr(ADDR_COMPARE, w);
      rd(ADDR_CONTROL, r);
      chk("control", 16'(r), 16'(c & 8'h7f));
      rd(ADDR_COUNT, r);
      chk("count", 16'(r), 16'(v));
      rd(ADDR_COMPARE, r);
      chk("compare", 16'(r), 16'(w));
      chk("force_out", 16'(cout), 16'(c[CTL_FORCE_BIT] ? force_exp(a, o) : o));
      chk("force_flag", 16'(cmpf), 16'h0000);
      rd(ADDR_COUNT, r);
      chk("stopped", 16'(r), 16'(v));
      chk("pin", 16'(cpin), 16'((a != 2'h0) ? cout : pdata));
      chk("pin_oe_n", 16'(coe_n), 16'(!dir));
    end
    // overflow spacing, normal then phase correct
    wr(ADDR_CONTROL, ctl(2'h0, 2'h0, 3'h1, 1'b0));
    period(0, 256, 1'b0);
    wr(ADDR_CONTROL, ctl(2'h1, 2'h0, 3'h1, 1'b0));
    period(0, PC_PERIOD, 1'b0);
    wr(ADDR_COMPARE, 8'($urandom_range(1, 254)));
    wr(ADDR_CONTROL, ctl(2'h1, 2'h2, 3'h1, 1'b0));
    period(2, PC_PERIOD, 1'b0);
    wr(ADDR_COMPARE, CNT_BOTTOM);
    steady(1'b0);
    wr(ADDR_COMPARE, CNT_MAX);
    steady(1'b1);
    wr(ADDR_CONTROL, ctl(2'h1, 2'h3, 3'h1, 1'b0));
    steady(1'b0);
    wr(ADDR_COMPARE, 8'($urandom_range(1, 254)));
    wr(ADDR_CONTROL, ctl(2'h3, 2'h2, 3'h1, 1'b0));
    period(2, 256, 1'b0);
    wr(ADDR_COMPARE, CNT_MAX);
    steady(1'b1);
    k = $urandom_range(2, 60);
    wr(ADDR_COMPARE, 8'(k));
    wr(ADDR_CONTROL, ctl(2'h2, 2'h1, 3'h1, 1'b0));
    period(2, 2 * (k + 1), 1'b0);
    // a count write hides the match of the next tick
    wr(ADDR_CONTROL, ctl(2'h0, 2'h0, 3'h0, 1'b0));
    wr(ADDR_STATUS, 8'h03);
    wr(ADDR_COUNT, 8'h80);
    wr(ADDR_COMPARE, 8'h80);
    wr(ADDR_CONTROL, ctl(2'h0, 2'h0, 3'h1, 1'b0));
    rd(ADDR_STATUS, r);
    chk("blocked", 16'(r), 16'h0000);
    wait_hi(1, t);
    k = $urandom_range(1, 2);
    wr(ADDR_CONTROL, ctl(2'h0, 2'h0, 3'(k), 1'b0));
    period(0, 256 * divs[k], 1'b0);
    test_done();
  end
endmodule
